// File: src/pmt_map.svh
// Constants: offsets, field positions, reset values and timing counts
`ifndef PMT_MAP_SVH
`define PMT_MAP_SVH

// ****************************
// Program store
// ****************************
`define PMT_PM_WORDS    4096
`define PMT_RESET_VEC   12'h000
`define PMT_TPH_HI_LSB  0
`define PMT_TPH_HI_MSB  3

// ****************************
// Data memory
// ****************************
`define PMT_GP_BIT      7
`define PMT_DM_BYTES    256
`define PMT_OFS_IND     7'h02
`define PMT_OFS_SP_LO   7'h03
`define PMT_OFS_SP_HI   7'h04
`define PMT_OFS_TP_LO   7'h07
`define PMT_OFS_THL     7'h08
`define PMT_OFS_TP_HI   7'h09
`define PMT_OFS_STAT    7'h0A
`define PMT_RST_BYTE    8'h00
`define PMT_UNUSED_RD   8'h00
`define PMT_NV_BYTES    64

// ****************************
// Timing
// ****************************
`define PMT_TPHASES     4
`define PMT_CLK_MHZ     250
`define PMT_IDLE_NS     1000
`define PMT_IDLE_CYC    ((`PMT_IDLE_NS * `PMT_CLK_MHZ) / 1000)
`define PMT_SER_HDR     14
`define PMT_SER_FRAME   30

`endif

// File: src/pmt_pkg.sv
// Types shared by the table-read memory block
package pmt_pkg;

  typedef enum logic [1:0] {
    PMT_TS_IDLE = 2'b00,
    PMT_TS_XFER = 2'b01,
    PMT_TS_DONE = 2'b11
  } pmt_tbl_e;

  typedef enum logic [1:0] {
    PMT_OP_WR_PM = 2'b00,
    PMT_OP_WR_NV = 2'b01,
    PMT_OP_RD_PM = 2'b10,
    PMT_OP_RD_NV = 2'b11
  } pmt_op_e;

  typedef logic [8:0] pmt_daddr_t;

endpackage

// File: src/pmt_prog_serial.sv
// Serial in-circuit programming port: one data line, one clock line
`timescale 1ns/1ps
`default_nettype none
`include "pmt_map.svh"

module pmt_prog_serial (
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rstn_i,
  // Programming pins
  input  wire logic              prog_serial_clock_i,
  input  wire logic              prog_serial_data_i,
  output logic                   ser_data_o,
  output logic                   ser_drive_o,
  // Store access
  input  wire logic [15:0]       rd_word_i,
  output pmt_pkg::pmt_op_e       op_o,
  output logic [11:0]            addr_o,
  output logic [15:0]            wdata_o,
  output logic                   wr_o,
  output logic                   active_o
);
  import pmt_pkg::*;

  logic        ck1_q, ck2_q, ck3_q, dt1_q, dt2_q;
  logic        rise;
  logic [4:0]  cnt_q, cnt_d;
  logic [29:0] sh_q, sh_d;
  logic [7:0]  idle_q, idle_d;
  pmt_op_e     op_q, op_d;
  logic [11:0] addr_q, addr_d;
  logic [15:0] wdata_q, wdata_d, out_q, out_d;
  logic        wr_q, wr_d, load_q, load_d, drv_q, drv_d;

  // ****************************
  // Pin synchronisers
  // ****************************
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ck1_q <= 1'b0;
      ck2_q <= 1'b0;
      ck3_q <= 1'b0;
      dt1_q <= 1'b0;
      dt2_q <= 1'b0;
    end else begin
      ck1_q <= prog_serial_clock_i;
      ck2_q <= ck1_q;
      ck3_q <= ck2_q;
      dt1_q <= prog_serial_data_i;
      dt2_q <= dt1_q;
    end
  end

  assign rise = ck2_q & ~ck3_q;

  // ****************************
  // Frame shifter
  // ****************************
  always_comb begin
    sh_d    = sh_q;
    cnt_d   = cnt_q;
    idle_d  = idle_q;
    op_d    = op_q;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    out_d   = out_q;
    drv_d   = drv_q;
    wr_d    = 1'b0;
    load_d  = 1'b0;
    if (rise) begin
      sh_d   = {sh_q[28:0], dt2_q};
      cnt_d  = cnt_q + 5'h01;
      idle_d = 8'h00;
      if (drv_q) begin
        // Shift after the programmer has sampled on this edge
        out_d = {out_q[14:0], 1'b0};
      end
      if (cnt_q == 5'(`PMT_SER_HDR - 1)) begin
        op_d   = pmt_op_e'(sh_d[13:12]);
        addr_d = sh_d[11:0];
        load_d = sh_d[13];
      end
      if (cnt_q == 5'(`PMT_SER_FRAME - 1)) begin
        cnt_d = 5'h00;
        drv_d = 1'b0;
        if (!op_q[1]) begin
          wdata_d = sh_d[15:0];
          wr_d    = 1'b1;
        end
      end
    end else if (cnt_q != 5'h00 || drv_q) begin
      // A stalled clock abandons the frame, so a cut cable cannot wedge it
      if (idle_q == 8'(`PMT_IDLE_CYC - 1)) begin
        cnt_d  = 5'h00;
        drv_d  = 1'b0;
        idle_d = 8'h00;
      end else begin
        idle_d = idle_q + 8'h01;
      end
    end
    if (load_q) begin
      out_d = rd_word_i;
      drv_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sh_q    <= 30'h0000_0000;
      cnt_q   <= 5'h00;
      idle_q  <= 8'h00;
      op_q    <= PMT_OP_WR_PM;
      addr_q  <= 12'h000;
      wdata_q <= 16'h0000;
      out_q   <= 16'h0000;
      drv_q   <= 1'b0;
      wr_q    <= 1'b0;
      load_q  <= 1'b0;
    end else begin
      sh_q    <= sh_d;
      cnt_q   <= cnt_d;
      idle_q  <= idle_d;
      op_q    <= op_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      out_q   <= out_d;
      drv_q   <= drv_d;
      wr_q    <= wr_d;
      load_q  <= load_d;
    end
  end

  assign ser_data_o  = out_q[15];
  assign ser_drive_o = drv_q;
  assign op_o        = op_q;
  assign addr_o      = addr_q;
  assign wdata_o     = wdata_q;
  assign wr_o        = wr_q;
  assign active_o    = (cnt_q != 5'h00) | drv_q;

endmodule
`default_nettype wire

// File: src/pmt_table_mem.sv
// Program store, table read, sectored data memory and programming port
// Behaviour
// - Program store holds 4K sixteen-bit words
// - Fetching starts at address zero after reset
// - Table address formed from both table pointers
// - Word low byte goes to operand location
// - Word high byte goes to latch
// - Standard table read targets sector zero, except through the indirect offset 02H
// - Low pointer is offset within high-pointer page
// - Table instructions take two instruction cycles
// - Latch is software read/write, never auto-saved
// - Software should mask interrupts around table reads
// - Serial programming over one data, one clock
// - Program store and nonvolatile data are programmable
// - Emulation keeps programming pins, drops shared function once the strap is sampled after reset
// - Data memory is byte wide
// - Two sectors, each register and general area
// - Offsets 00H-7FH are special registers
// - Offsets 80H-FFH are general storage
// - General storage is read and write
// - Some special registers ignore writes
// - Memory pointers choose the accessed sector
// - High pointer sector, low pointer byte
// - Unused special addresses read 00H
`timescale 1ns/1ps
`default_nettype none
`include "pmt_map.svh"

module pmt_table_mem (
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rstn_i,
  // Instruction fetch
  input  wire logic              jump_i,
  input  wire logic [11:0]       jump_addr_i,
  output logic [15:0]            instr_o,
  output logic [11:0]            pc_o,
  output logic                   icyc_o,
  // Table read
  input  wire logic              tbl_req_i,
  input  wire logic              ext_table_read_instr_i,
  input  wire pmt_pkg::pmt_daddr_t tbl_dest_i,
  output logic                   tbl_busy_o,
  output logic                   tbl_done_o,
  // Data access
  input  wire logic              dm_req_i,
  input  wire logic              dm_we_i,
  input  wire logic              dm_ext_i,
  input  wire pmt_pkg::pmt_daddr_t dm_addr_i,
  input  wire logic [7:0]        dm_wdata_i,
  output logic [7:0]             dm_rdata_o,
  // Programming pins
  input  wire logic              prog_serial_clock_i,
  input  wire logic              prog_serial_data_i,
  output logic                   prog_serial_data_o,
  output logic                   prog_serial_data_oe_o,
  // Shared pin function and strap
  input  wire logic              emu_strap_i,
  input  wire logic              gpio_dat_i,
  input  wire logic              gpio_oe_i
);
  import pmt_pkg::*;

  logic [15:0] pmem [`PMT_PM_WORDS];
  logic [7:0]  dmem [`PMT_DM_BYTES];
  logic [7:0]  nvmem [`PMT_NV_BYTES];

  logic [1:0]  ph_q, ph_d;
  logic [11:0] pc_q, pc_d, taddr_q, taddr_d;
  logic [15:0] instr_q, instr_d, tword, ser_rd;
  pmt_tbl_e    st_q, st_d;
  pmt_daddr_t  tdest_q, tdest_d, dm_eff, dw_addr;
  logic [7:0]  sp_lo_q, sp_lo_d, sp_hi_q, sp_hi_d, tp_lo_q, tp_lo_d;
  logic [7:0]  tp_hi_q, tp_hi_d, thl_q, thl_d, rd_q, rd_d, dw_data;
  logic        icyc, tbl_go, xfer, dm_take, dw_en;
  logic        es1_q, es2_q, emu_q, emu_d;
  logic [2:0]  cap_q;
  logic        ser_dat, ser_drv, ser_wr, ser_act;
  pmt_op_e     ser_op;
  logic [11:0] ser_addr;
  logic [15:0] ser_wdata;

  // ****************************
  // Helpers
  // ****************************
  function automatic pmt_daddr_t eff_addr(input logic ext, input pmt_daddr_t a,
                                          input logic [7:0] hi, input logic [7:0] lo);
    pmt_daddr_t r;
    r = {ext & a[8], a[7:0]};
    if (r[7:0] == {1'b0, `PMT_OFS_IND}) begin
      r = {hi[0], lo};
    end
    return r;
  endfunction

  function automatic logic sfr_mapped(input logic [6:0] ofs);
    return ofs == `PMT_OFS_SP_LO || ofs == `PMT_OFS_SP_HI || ofs == `PMT_OFS_TP_LO
        || ofs == `PMT_OFS_THL || ofs == `PMT_OFS_TP_HI || ofs == `PMT_OFS_STAT;
  endfunction

  // ****************************
  // Instruction cycle and fetch
  // ****************************
  assign icyc = (ph_q == 2'(`PMT_TPHASES - 1));

  always_comb begin
    ph_d    = ph_q + 2'h1;
    pc_d    = pc_q;
    instr_d = instr_q;
    if (icyc && st_q == PMT_TS_IDLE) begin
      instr_d = pmem[pc_q];
      pc_d    = jump_i ? jump_addr_i : pc_q + 12'h001;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ph_q    <= 2'h0;
      pc_q    <= `PMT_RESET_VEC;
      instr_q <= 16'h0000;
    end else begin
      ph_q    <= ph_d;
      pc_q    <= pc_d;
      instr_q <= instr_d;
    end
  end

  // ****************************
  // Table read sequencer
  // ****************************
  assign tbl_go  = icyc & tbl_req_i & (st_q == PMT_TS_IDLE);
  assign xfer    = icyc & (st_q == PMT_TS_XFER);
  assign tword   = pmem[taddr_q];
  assign dm_take = icyc & dm_req_i & ~tbl_req_i & (st_q == PMT_TS_IDLE);
  assign dm_eff  = eff_addr(dm_ext_i, dm_addr_i, sp_hi_q, sp_lo_q);

  always_comb begin
    st_d    = st_q;
    taddr_d = taddr_q;
    tdest_d = tdest_q;
    unique case (st_q)
      PMT_TS_IDLE: begin
        if (tbl_go) begin
          // Page from high pointer, offset from low pointer
          taddr_d = {tp_hi_q[`PMT_TPH_HI_MSB:`PMT_TPH_HI_LSB], tp_lo_q};
          tdest_d = eff_addr(ext_table_read_instr_i, tbl_dest_i, sp_hi_q, sp_lo_q);
          st_d    = PMT_TS_XFER;
        end
      end
      PMT_TS_XFER: begin
        if (icyc) begin
          st_d = PMT_TS_DONE;
        end
      end
      PMT_TS_DONE: begin
        if (icyc) begin
          st_d = PMT_TS_IDLE;
        end
      end
      default: st_d = PMT_TS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q    <= PMT_TS_IDLE;
      taddr_q <= 12'h000;
      tdest_q <= 9'h000;
    end else begin
      st_q    <= st_d;
      taddr_q <= taddr_d;
      tdest_q <= tdest_d;
    end
  end

  assign tbl_busy_o = (st_q != PMT_TS_IDLE);
  assign tbl_done_o = icyc & (st_q == PMT_TS_DONE);

  // ****************************
  // Data write port and registers
  // ****************************
  always_comb begin
    dw_en   = 1'b0;
    dw_addr = tdest_q;
    dw_data = tword[7:0];
    if (xfer) begin
      dw_en = 1'b1;
    end else if (dm_take && dm_we_i) begin
      dw_en   = 1'b1;
      dw_addr = dm_eff;
      dw_data = dm_wdata_i;
    end
  end

  always_comb begin
    sp_lo_d = sp_lo_q;
    sp_hi_d = sp_hi_q;
    tp_lo_d = tp_lo_q;
    tp_hi_d = tp_hi_q;
    thl_d   = thl_q;
    rd_d    = rd_q;
    if (dw_en && !dw_addr[`PMT_GP_BIT]) begin
      unique case (dw_addr[6:0])
        `PMT_OFS_SP_LO: sp_lo_d = dw_data;
        `PMT_OFS_SP_HI: sp_hi_d = dw_data;
        `PMT_OFS_TP_LO: tp_lo_d = dw_data;
        `PMT_OFS_TP_HI: tp_hi_d = dw_data;
        `PMT_OFS_THL:   thl_d   = dw_data;
        // Status and unused offsets drop the write
        default: thl_d = thl_d;
      endcase
    end
    // No shadow copy: a handler's table read overwrites the latch
    if (xfer) begin
      thl_d = tword[15:8];
    end
    if (dm_take && !dm_we_i) begin
      if (dm_eff[`PMT_GP_BIT]) begin
        rd_d = dmem[{dm_eff[8], dm_eff[6:0]}];
      end else if (!sfr_mapped(dm_eff[6:0])) begin
        rd_d = `PMT_UNUSED_RD;
      end else begin
        unique case (dm_eff[6:0])
          `PMT_OFS_SP_LO: rd_d = sp_lo_q;
          `PMT_OFS_SP_HI: rd_d = sp_hi_q;
          `PMT_OFS_TP_LO: rd_d = tp_lo_q;
          `PMT_OFS_TP_HI: rd_d = tp_hi_q;
          `PMT_OFS_THL:   rd_d = thl_q;
          default:        rd_d = {5'h00, emu_q, ser_act, tbl_busy_o};
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sp_lo_q <= `PMT_RST_BYTE;
      sp_hi_q <= `PMT_RST_BYTE;
      tp_lo_q <= `PMT_RST_BYTE;
      tp_hi_q <= `PMT_RST_BYTE;
      thl_q   <= `PMT_RST_BYTE;
      rd_q    <= `PMT_RST_BYTE;
    end else begin
      sp_lo_q <= sp_lo_d;
      sp_hi_q <= sp_hi_d;
      tp_lo_q <= tp_lo_d;
      tp_hi_q <= tp_hi_d;
      thl_q   <= thl_d;
      rd_q    <= rd_d;
    end
  end

  // ****************************
  // Storage arrays
  // ****************************
  // Arrays carry no reset; contents are defined only once written
  always_ff @(posedge sys_clk_i) begin
    if (dw_en && dw_addr[`PMT_GP_BIT]) begin
      dmem[{dw_addr[8], dw_addr[6:0]}] <= dw_data;
    end
    if (ser_wr && ser_op == PMT_OP_WR_PM) begin
      pmem[ser_addr] <= ser_wdata;
    end
    if (ser_wr && ser_op == PMT_OP_WR_NV) begin
      nvmem[ser_addr[5:0]] <= ser_wdata[7:0];
    end
  end

  assign ser_rd = (ser_op == PMT_OP_RD_PM) ? pmem[ser_addr]
                                           : {8'h00, nvmem[ser_addr[5:0]]};

  // ****************************
  // Programming port and pin sharing
  // ****************************
  pmt_prog_serial u_ser (
    .sys_clk_i           (sys_clk_i),
    .rstn_i              (rstn_i),
    .prog_serial_clock_i (prog_serial_clock_i),
    .prog_serial_data_i  (prog_serial_data_i),
    .ser_data_o          (ser_dat),
    .ser_drive_o         (ser_drv),
    .rd_word_i           (ser_rd),
    .op_o                (ser_op),
    .addr_o              (ser_addr),
    .wdata_o             (ser_wdata),
    .wr_o                (ser_wr),
    .active_o            (ser_act)
  );

  // Strap is sampled once, after release, so reset holds only constants
  always_comb begin
    // Second sync stage holds the pin only from the second edge on
    emu_d = cap_q[2] ? emu_q : es2_q;
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      es1_q <= 1'b0;
      es2_q <= 1'b0;
      emu_q <= 1'b0;
      cap_q <= 3'h0;
    end else begin
      es1_q <= emu_strap_i;
      es2_q <= es1_q;
      emu_q <= emu_d;
      cap_q <= {cap_q[1:0], 1'b1};
    end
  end

  // Emulation part: shared pin function silenced once the strap is sampled after reset, programming still works
  assign prog_serial_data_oe_o = ser_drv | (~emu_q & ~ser_act & gpio_oe_i);
  assign prog_serial_data_o    = ser_drv ? ser_dat : gpio_dat_i;

  assign instr_o    = instr_q;
  assign pc_o       = pc_q;
  assign icyc_o     = icyc;
  assign dm_rdata_o = rd_q;

  // ****************************
  // Assertions
  // ****************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  logic fetched_q;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) fetched_q <= 1'b0;
    else if (icyc) fetched_q <= 1'b1;
  end

  AST_RESET_FETCH: assert property (icyc && !fetched_q |-> pc_q == 12'h000)
    else $error("first fetch not at address zero");
  AST_TBL_TWO_CYC: assert property (tbl_go |-> ##8 tbl_done_o)
    else $error("table read did not end after two instruction cycles");
  AST_TBL_ADDR: assert property (tbl_go |=>
                                 taddr_q == {$past(tp_hi_q[3:0]), $past(tp_lo_q)})
    else $error("table address not formed from pointers");
  AST_STD_SECTOR: assert property (tbl_go && !ext_table_read_instr_i
                                   && tbl_dest_i[7:0] != 8'h02 |=> !tdest_q[8])
    else $error("standard table read left sector zero");
  AST_LATCH_LOAD: assert property (xfer |=> thl_q == $past(tword[15:8]))
    else $error("latch not loaded with word high byte");
  AST_DEST_LOW: assert property (xfer && tdest_q[7] |=>
                                 dmem[{$past(tdest_q[8]), $past(tdest_q[6:0])}]
                                 == $past(tword[7:0]))
    else $error("low byte not written to destination");
  AST_UNUSED_ZERO: assert property (dm_take && !dm_we_i && !dm_eff[7]
                                    && !sfr_mapped(dm_eff[6:0]) |=> dm_rdata_o == 8'h00)
    else $error("unused register did not read zero");
  AST_GP_WRITE: assert property (dm_take && dm_we_i && dm_eff[7] |=>
                                 dmem[{$past(dm_eff[8]), $past(dm_eff[6:0])}]
                                 == $past(dm_wdata_i))
    else $error("general storage write lost");
  AST_PROG_WRITE: assert property (ser_wr && ser_op == PMT_OP_WR_PM |=>
                                   pmem[$past(ser_addr)] == $past(ser_wdata))
    else $error("programming write lost");
  AST_EMU_PIN: assert property (emu_q && !ser_drv |-> !prog_serial_data_oe_o)
    else $error("shared pin function active on emulation part");

  COV_TBL_STD: cover property (tbl_go && !ext_table_read_instr_i ##8 tbl_done_o);
  COV_TBL_EXT: cover property (tbl_go && ext_table_read_instr_i && tbl_dest_i[8]);
  COV_IND_RD: cover property (dm_take && !dm_we_i && dm_addr_i[7:0] == 8'h02);
  COV_PROG_WR: cover property (ser_wr);

endmodule
`default_nettype wire

// File: tb/pmt_core_model.sv
// Core model: fetch redirects, table reads and data accesses
`timescale 1ns/1ps
`default_nettype none

module pmt_core_model (
  // Clock and status
  input  wire logic          clk_i,
  input  wire logic          icyc_i,
  input  wire logic          done_i,
  // Core requests
  output logic               jump_o,
  output logic [11:0]        jump_addr_o,
  output logic               tbl_req_o,
  output logic               ext_o,
  output pmt_pkg::pmt_daddr_t dest_o,
  output logic               dm_req_o,
  output logic               dm_we_o,
  output logic               dm_ext_o,
  output pmt_pkg::pmt_daddr_t dm_addr_o,
  output logic [7:0]         dm_wdata_o
);
  import pmt_pkg::*;

  initial begin
    jump_o = 1'b0;
    jump_addr_o = 12'h000;
    tbl_req_o = 1'b0;
    ext_o = 1'b0;
    dest_o = 9'h000;
    dm_req_o = 1'b0;
    dm_we_o = 1'b0;
    dm_ext_o = 1'b0;
    dm_addr_o = 9'h000;
    dm_wdata_o = 8'h00;
  end

  // ****************************
  // Request timing
  // ****************************
  // Present for the last clock of one instruction cycle only, never at a done cycle
  task automatic sync();
    @(negedge clk_i);
    while (icyc_i !== 1'b1) @(negedge clk_i);
    repeat (4) @(posedge clk_i);
  endtask

  task automatic jmp(input logic [11:0] a);
    sync();
    jump_o <= 1'b1;
    jump_addr_o <= a;
    @(posedge clk_i);
    jump_o <= 1'b0;
    jump_addr_o <= ~a;
  endtask

  // No interrupts here, so latch use is never interleaved
  task automatic dm(input logic we, input logic ext, input pmt_daddr_t a,
                    input logic [7:0] d);
    sync();
    dm_req_o <= 1'b1;
    dm_we_o <= we;
    dm_ext_o <= ext;
    dm_addr_o <= a;
    dm_wdata_o <= d;
    @(posedge clk_i);
    dm_req_o <= 1'b0;
    dm_wdata_o <= ~d;
  endtask

  task automatic tbl(input logic ext, input pmt_daddr_t a, output int lat);
    sync();
    tbl_req_o <= 1'b1;
    ext_o <= ext;
    dest_o <= a;
    @(posedge clk_i);
    tbl_req_o <= 1'b0;
    dest_o <= ~a;
    lat = 0;
    do begin
      @(negedge clk_i);
      lat++;
    end while (done_i !== 1'b1 && lat < 20);
  endtask
endmodule
`default_nettype wire

// File: tb/pmt_table_mem_test.sv
// Self-checking bench for the table-read memory block
`timescale 1ns/1ps
`default_nettype none

module pmt_table_mem_test;
  import pmt_pkg::*;
  logic        sys_clk, rstn, sck, pbit, pdrv, tog, emu, gdat, goe;
  wire logic   jump, tbl_req, ext, dm_req, dm_we, dm_ext, icyc, busy, done, sdo, soe, pin;
  wire logic [11:0] jaddr, pc;
  wire logic [15:0] instr;
  wire pmt_daddr_t  dest, daddr;
  wire logic [7:0]  wdat, rdat;
  logic [7:0]  exp_q[$];
  logic [31:0] seed;
  logic [15:0] w1, w2, rw;
  logic [7:0]  b, a;
  int          err_count, compares, lat;

  // Released line shows a changing pattern, not the last bit
  assign pin = soe ? sdo : (pdrv ? pbit : tog);

  pmt_table_mem u_pmt_table_mem (.sys_clk_i(sys_clk), .rstn_i(rstn), .jump_i(jump),
    .jump_addr_i(jaddr), .instr_o(instr), .pc_o(pc), .icyc_o(icyc), .tbl_req_i(tbl_req),
    .ext_table_read_instr_i(ext), .tbl_dest_i(dest), .tbl_busy_o(busy), .tbl_done_o(done),
    .dm_req_i(dm_req), .dm_we_i(dm_we), .dm_ext_i(dm_ext), .dm_addr_i(daddr),
    .dm_wdata_i(wdat), .dm_rdata_o(rdat), .prog_serial_clock_i(sck),
    .prog_serial_data_i(pin), .prog_serial_data_o(sdo), .prog_serial_data_oe_o(soe),
    .emu_strap_i(emu), .gpio_dat_i(gdat), .gpio_oe_i(goe));

  pmt_core_model u_pmt_core_model (.clk_i(sys_clk), .icyc_i(icyc), .done_i(done),
    .jump_o(jump), .jump_addr_o(jaddr), .tbl_req_o(tbl_req), .ext_o(ext), .dest_o(dest),
    .dm_req_o(dm_req), .dm_we_o(dm_we), .dm_ext_o(dm_ext), .dm_addr_o(daddr),
    .dm_wdata_o(wdat));

  // ****************************
  // Helpers
  // ****************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] s);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic conclude();
    if (exp_q.size() != 0) begin
      err_count++;
      $display("mismatch pending_reads expected 0 seen %0d", exp_q.size());
    end
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic x, input pmt_daddr_t ad, input logic [7:0] d);
    u_pmt_core_model.dm(1'b1, x, ad, d);
  endtask

  task automatic rd(input logic x, input pmt_daddr_t ad, input logic [7:0] e);
    exp_q.push_back(e);
    u_pmt_core_model.dm(1'b0, x, ad, 8'h00);
  endtask

  // Programmer clock stands still low between frames
  task automatic frame(input logic [1:0] op, input logic [11:0] ad, input logic [15:0] d,
                       output logic [15:0] r);
    logic [29:0] f;
    f = {op, ad, d};
    r = 16'h0000;
    for (int i = 0; i < 30; i++) begin
      @(posedge sys_clk);
      pdrv <= (i < 14) || !op[1];
      pbit <= f[29 - i];
      repeat (5) @(posedge sys_clk);
      if (i >= 14) r = {r[14:0], pin};
      sck <= 1'b1;
      repeat (5) @(posedge sys_clk);
      sck <= 1'b0;
    end
    pdrv <= 1'b0;
    repeat (12) @(posedge sys_clk);
  endtask

  // ****************************
  // Clock, watchers, sequence
  // ****************************
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) tog <= ~tog;

  always @(posedge sys_clk) begin
    if (rstn && icyc === 1'b1 && dm_req && !dm_we && !tbl_req && busy === 1'b0) begin
      @(negedge sys_clk);
      chk("dm_rdata", {8'h00, exp_q.pop_front()}, {8'h00, rdat});
    end
  end

  initial begin
    #100000;
    err_count++;
    conclude();
  end

  initial begin
    rstn = 1'b0;
    sck = 1'b0;
    pbit = 1'b0;
    pdrv = 1'b0;
    tog = 1'b0;
    emu = 1'b0;
    gdat = 1'b0;
    goe = 1'b0;
    seed = 32'd51717;
    err_count = 0;
    compares = 0;
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    @(negedge sys_clk);
    while (icyc !== 1'b1) @(negedge sys_clk);
    chk("pc", 16'h0000, {4'h0, pc});
    @(negedge sys_clk);
    chk("pc", 16'h0001, {4'h0, pc});
    w1 = 16'(rnd());
    w2 = 16'(rnd());
    b = 8'(rnd());
    frame(2'b00, 12'hF06, w1, rw);
    frame(2'b00, 12'hF05, w2, rw);
    frame(2'b10, 12'hF06, 16'h0000, rw);
    chk("serial_rd", w1, rw);
    frame(2'b01, 12'h015, {8'h00, b}, rw);
    frame(2'b11, 12'h015, 16'h0000, rw);
    chk("nv_rd", {8'h00, b}, rw);
    u_pmt_core_model.jmp(12'hF06);
    @(negedge sys_clk);
    chk("pc", 16'h0F06, {4'h0, pc});
    while (icyc !== 1'b1) @(negedge sys_clk);
    @(negedge sys_clk);
    chk("instr", w1, instr);
    wr(1'b0, 9'h007, 8'h06);
    wr(1'b0, 9'h009, 8'hAF);
    u_pmt_core_model.tbl(1'b0, 9'h185, lat);
    chk("tbl_latency", 16'd8, 16'(lat));
    rd(1'b0, 9'h085, w1[7:0]);
    rd(1'b0, 9'h008, w1[15:8]);
    wr(1'b0, 9'h007, 8'h05);
    u_pmt_core_model.tbl(1'b1, 9'h1A0, lat);
    chk("tbl_latency", 16'd8, 16'(lat));
    rd(1'b1, 9'h1A0, w2[7:0]);
    rd(1'b1, 9'h108, w2[15:8]);
    wr(1'b0, 9'h008, b);
    rd(1'b0, 9'h008, b);
    for (int i = 0; i < 4; i++) begin
      a = 8'(rnd()) | 8'h80;
      b = 8'(rnd());
      wr(1'b1, {1'b0, a}, b);
      wr(1'b1, {1'b1, a}, ~b);
      rd(1'b1, {1'b0, a}, b);
      rd(1'b1, {1'b1, a}, ~b);
    end
    wr(1'b0, 9'h00A, 8'hFF);
    rd(1'b0, 9'h00A, 8'h00);
    wr(1'b0, 9'h020, 8'h55);
    rd(1'b0, 9'h020, 8'h00);
    wr(1'b0, 9'h003, 8'hC3);
    wr(1'b0, 9'h004, 8'h01);
    wr(1'b0, 9'h002, b);
    rd(1'b1, 9'h1C3, b);
    wr(1'b0, 9'h004, 8'h00);
    wr(1'b0, 9'h0C3, ~b);
    rd(1'b0, 9'h002, ~b);
    // Let the last read result show before reset clears it
    repeat (2) @(posedge sys_clk);
    gdat <= seed[3];
    rstn <= 1'b0;
    emu <= 1'b1;
    goe <= 1'b1;
    repeat (10) @(posedge sys_clk);
    chk("pin_oe_rst", 16'h0001, {15'h0000, soe});
    chk("pin_dat", {15'h0000, gdat}, {15'h0000, sdo});
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (10) @(posedge sys_clk);
    chk("pin_oe", 16'h0000, {15'h0000, soe});
    // Cut frame: the stalled clock must abandon it
    repeat (3) begin
      sck <= 1'b1;
      repeat (5) @(posedge sys_clk);
      sck <= 1'b0;
      repeat (5) @(posedge sys_clk);
    end
    repeat (260) @(posedge sys_clk);
    frame(2'b10, 12'hF05, 16'h0000, rw);
    chk("serial_rd", w2, rw);
    conclude();
  end
endmodule
`default_nettype wire
